/* File: src/uasd_master.sv */
// Purpose: Master end: turns user commands into legal shared-bus accesses
// Assumes: Decoder acks every request one cycle after it is taken
// Notes: Illegal commands are refused locally and never reach the bus
`timescale 1ns/1ns
`default_nettype none
module uasd_master #(
   parameter logic [15:0] RAM_HI = uasd_pkg::RAM_HI_DEF,
   parameter logic [15:0] PMEM_LO = uasd_pkg::PMEM_LO_DEF
) (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RESET,
   // Command from the user
   input wire logic CMD_VALID,
   output logic CMD_READY,
   input wire logic CMD_WRITE,
   input wire logic CMD_BYTE,
   input wire logic CMD_FETCH,
   input wire logic [15:0] CMD_ADDR,
   input wire logic [15:0] CMD_WDATA,
   // Response to the user
   output logic RSP_VALID,
   output logic RSP_ERROR,
   output logic [15:0] RSP_DATA,
   // Shared bus toward the decoder
   uasd_bus_if.mst bus
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum {MS_IDLE, MS_BUSY} uasd_mstate_e;
   uasd_mstate_e state_reg;               // Idle or waiting for ack
   logic req_reg;                         // Request on the bus
   logic wr_reg;
   logic byte_reg;
   logic fetch_reg;
   logic [15:0] addr_reg;
   logic [15:0] wdata_reg;
   logic rsp_valid_reg;                   // One-cycle response strobe
   logic rsp_error_reg;
   logic [15:0] rsp_data_reg;
   logic legal;                           // Command obeys the access rules
   logic take;                            // Command accepted this cycle
   uasd_pkg::uasd_region_e cmd_region;

   assign cmd_region = uasd_pkg::region_of(CMD_ADDR, RAM_HI, PMEM_LO);

   // Checked before issue so the bus only carries legal accesses
   always_comb begin
      legal = 1'b1;
      if (CMD_FETCH && (CMD_ADDR[0] || CMD_BYTE || CMD_WRITE)) begin
         legal = 1'b0;
      end
      if (!CMD_BYTE && CMD_ADDR[0]) begin
         legal = 1'b0;
      end
      if (!CMD_BYTE && (cmd_region == uasd_pkg::RG_SFB)) begin
         legal = 1'b0;
      end
      if (CMD_BYTE && CMD_ADDR[0] && (cmd_region == uasd_pkg::RG_PER16)) begin
         legal = 1'b0;
      end
   end

   assign CMD_READY = (state_reg == MS_IDLE);
   assign take = CMD_VALID && CMD_READY;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   // Idle until a legal command, then busy until the decoder acks
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         state_reg <= MS_IDLE;
      end else begin
         unique case (state_reg)
            MS_IDLE: begin
               if (take && legal) begin
                  state_reg <= MS_BUSY;
               end
            end
            MS_BUSY: begin
               if (bus.ack) begin
                  state_reg <= MS_IDLE;
               end
            end
         endcase
      end
   end

   // Bus request, held until the ack cycle
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         req_reg <= 1'b0;
         wr_reg <= 1'b0;
         byte_reg <= 1'b0;
         fetch_reg <= 1'b0;
         addr_reg <= uasd_pkg::WORD_ZERO;
         wdata_reg <= uasd_pkg::WORD_ZERO;
      end else if (take && legal) begin
         req_reg <= 1'b1;
         wr_reg <= CMD_WRITE;
         byte_reg <= CMD_BYTE;
         fetch_reg <= CMD_FETCH;
         addr_reg <= CMD_ADDR;
         wdata_reg <= CMD_WDATA;
      end else if (bus.ack) begin
         req_reg <= 1'b0;
      end
   end

   // Response: refusals answer one cycle after the command, accesses one cycle after the ack cycle
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         rsp_valid_reg <= 1'b0;
         rsp_error_reg <= 1'b0;
         rsp_data_reg <= uasd_pkg::WORD_ZERO;
      end else begin
         rsp_valid_reg <= (take && !legal) || ((state_reg == MS_BUSY) && bus.ack);
         if (take && !legal) begin
            rsp_error_reg <= 1'b1;
            rsp_data_reg <= uasd_pkg::WORD_ZERO;
         end else if ((state_reg == MS_BUSY) && bus.ack) begin
            rsp_error_reg <= 1'b0;
            rsp_data_reg <= wr_reg ? uasd_pkg::WORD_ZERO : bus.shared_data_bus_rd;
         end
      end
   end

   assign bus.req = req_reg;
   assign bus.wr = wr_reg;
   assign bus.byte_acc = byte_reg;
   assign bus.fetch = fetch_reg;
   assign bus.shared_address_bus = addr_reg;
   assign bus.shared_data_bus_wr = wdata_reg;
   assign RSP_VALID = rsp_valid_reg;
   assign RSP_ERROR = rsp_error_reg;
   assign RSP_DATA = rsp_data_reg;

endmodule
`default_nettype wire

/* File: src/uasd_pkg.sv */
// Purpose: Shared constants, region type and decode function for the address decoder
// Assumes: 16-bit address and data, byte-addressed little-endian map
// Notes: Both bus ends use region_of so they agree on every boundary
package uasd_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 16;               // 64 KB byte address space
   localparam int DATA_W = 16;               // Word width of the core
   localparam int BYTE_W = 8;                // One byte lane

   // ----------------------------------------------------------------
   // Region boundaries (inclusive)
   // ----------------------------------------------------------------
   localparam logic [15:0] SFB_LO = 16'h0000;     // Special-function byte area
   localparam logic [15:0] SFB_HI = 16'h000f;
   localparam logic [15:0] PER8_LO = 16'h0010;    // Byte-wide peripherals
   localparam logic [15:0] PER8_HI = 16'h00ff;
   localparam logic [15:0] PER16_LO = 16'h0100;   // Word-wide peripherals
   localparam logic [15:0] PER16_HI = 16'h01ff;
   localparam logic [15:0] RAM_LO = 16'h0200;     // RAM start is fixed
   localparam logic [15:0] RAM_HI_DEF = 16'h09ff; // Default top of fitted RAM
   localparam logic [15:0] PMEM_LO_DEF = 16'hf000; // Default start of program memory
   localparam logic [15:0] PMEM_HI = 16'hffff;    // Program memory always ends here
   localparam logic [15:0] VEC_LO = 16'hffe0;     // Top sixteen words hold vectors
   localparam logic [15:0] VEC_TOP = 16'hfffe;    // Highest-priority vector word

   // ----------------------------------------------------------------
   // Lane constants
   // ----------------------------------------------------------------
   localparam logic [1:0] BE_LO = 2'h1;      // Low lane, even byte
   localparam logic [1:0] BE_HI = 2'h2;      // High lane, odd byte
   localparam logic [1:0] BE_BOTH = 2'h3;    // Whole word
   localparam logic [1:0] BE_NONE = 2'h0;
   localparam logic [7:0] BYTE_ZERO = 8'h00; // Fill for byte results
   localparam logic [15:0] WORD_ZERO = 16'h0000;

   // ----------------------------------------------------------------
   // Regions; RG_NONE is the unmapped hole
   // ----------------------------------------------------------------
   typedef enum {RG_SFB, RG_PER8, RG_PER16, RG_RAM, RG_PMEM, RG_NONE} uasd_region_e;
   localparam int NUM_REGIONS = 5;           // Selectable regions, RG_NONE excluded

   // Map one byte address to its region
   function automatic uasd_region_e region_of(input logic [15:0] a,
                                              input logic [15:0] ram_hi,
                                              input logic [15:0] pmem_lo);
      uasd_region_e r;
      r = RG_NONE;
      if (a <= SFB_HI) begin
         r = RG_SFB;
      end else if (a <= PER8_HI) begin
         r = RG_PER8;
      end else if (a <= PER16_HI) begin
         r = RG_PER16;
      end else if (a <= ram_hi) begin
         r = RG_RAM;
      end else if (a >= pmem_lo) begin
         r = RG_PMEM;
      end
      return r;
   endfunction

endpackage

/* File: src/uasd_bus_if.sv */
// Purpose: Shared address and data bus between a master and the decoder
// Assumes: One clock; master holds a request until acknowledged
// Notes: Read and write data travel on separate one-way halves
`timescale 1ns/1ns
`default_nettype none
interface uasd_bus_if;
   logic req;                        // Access request, held until ack
   logic wr;                         // 1 write, 0 read
   logic byte_acc;                   // 1 byte access, 0 word access
   logic fetch;                      // Instruction fetch
   logic [15:0] shared_address_bus;  // Byte address
   logic [15:0] shared_data_bus_wr;  // Write data, byte in low lane
   logic ack;                        // One-cycle completion
   logic [15:0] shared_data_bus_rd;  // Read result, byte right-justified

   modport dev (input req, wr, byte_acc, fetch, shared_address_bus, shared_data_bus_wr,
                output ack, shared_data_bus_rd);
   modport mst (output req, wr, byte_acc, fetch, shared_address_bus, shared_data_bus_wr,
                input ack, shared_data_bus_rd);
endinterface
`default_nettype wire

/* File: src/uasd_decoder.sv */
// Purpose: Decoder end: routes each mapped shared-bus access to one region with lane handling
// Assumes: Regions answer reads combinationally in the select cycle
// Notes: One access per request; select and write strobe last one cycle
// Notes on behaviour
// - One 64 KB map shared by everything
// - Lowest sixteen bytes are byte-only function area
// - 010h-0FFh selects byte-wide peripheral region
// - Word read of byte peripheral: upper byte undefined
// - Word write to byte peripheral writes low byte
// - 0100h-01FFh selects word-wide peripheral region
// - Byte access to word peripheral: even, upper zero
// - Program memory ends 0FFFFh, start is parameter
// - Top sixteen words are vectors, top 0FFFEh
// - Fetches always use even addresses
// - Bytes any address, words even only
// - Low byte even address, high byte odd
// - Program memory serves fetches and data reads
// - One shared address bus and data bus
`timescale 1ns/1ns
`default_nettype none
module uasd_decoder #(
   parameter logic [15:0] RAM_HI = uasd_pkg::RAM_HI_DEF,
   parameter logic [15:0] PMEM_LO = uasd_pkg::PMEM_LO_DEF
) (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RESET,
   // Shared bus from the masters
   uasd_bus_if.dev bus,
   // Region selects, one bit per region
   output logic [uasd_pkg::NUM_REGIONS-1:0] REGION_SEL,
   // Region access signals, common to all regions
   output logic [15:0] REGION_ADDR,
   output logic REGION_WE,
   output logic [1:0] REGION_BE,
   output logic [15:0] REGION_WDATA,
   // Region read data, one word per region
   input wire logic [uasd_pkg::NUM_REGIONS-1:0][15:0] REGION_RDATA,
   // Status of the last access
   output logic ACCESS_FAULT,
   output logic VECTOR_HIT
);

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic ack_reg;                         // Completion flag toward the master
   logic [15:0] rdata_reg;                // Registered read result
   logic fault_reg;                       // Last access broke an access rule
   logic vec_reg;                         // Last access hit the vector table
   logic live;                            // First cycle of a request
   logic odd;                             // Byte lane select
   logic narrow;                          // Region holds byte-wide registers
   logic fault;                           // Access breaks a width or alignment rule
   logic [15:0] lane_word;                // Word read from the selected region
   logic [15:0] rdata_next;               // Result after lane handling
   uasd_pkg::uasd_region_e region;        // Region of the current address

   // A held request counts once: the ack cycle is masked out
   assign live = bus.req && !ack_reg;
   assign odd = bus.shared_address_bus[0];
   // Full 16-bit address covers the 64 KB map directly
   assign region = uasd_pkg::region_of(bus.shared_address_bus, RAM_HI, PMEM_LO);
   assign narrow = (region == uasd_pkg::RG_SFB) || (region == uasd_pkg::RG_PER8);

   // One select per region, only in the live cycle; RG_NONE drives none
   genvar gi;
   generate
      for (gi = 0; gi < uasd_pkg::NUM_REGIONS; gi++) begin : g_sel
         assign REGION_SEL[gi] = live && (region == uasd_pkg::uasd_region_e'(gi));
      end
   endgenerate

   // ----------------------------------------------------------------
   // Write path
   // ----------------------------------------------------------------
   // Words always land on the even address; the stray bit is dropped
   assign REGION_ADDR = {bus.shared_address_bus[15:1], 1'b0};
   // Program memory is read-only on this bus; writes there are not strobed
   assign REGION_WE = live && bus.wr && (region != uasd_pkg::RG_NONE)
                      && (region != uasd_pkg::RG_PMEM);

   // Byte enables and lane placement
   always_comb begin
      if (bus.byte_acc) begin
         // Byte copied to both lanes; enable picks the even or odd one
         REGION_BE = odd ? uasd_pkg::BE_HI : uasd_pkg::BE_LO;
         REGION_WDATA = {bus.shared_data_bus_wr[7:0], bus.shared_data_bus_wr[7:0]};
      end else if (narrow) begin
         // Word write to a byte register keeps only the low byte
         REGION_BE = uasd_pkg::BE_LO;
         REGION_WDATA = bus.shared_data_bus_wr;
      end else begin
         REGION_BE = uasd_pkg::BE_BOTH;
         REGION_WDATA = bus.shared_data_bus_wr;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   always_comb begin
      lane_word = uasd_pkg::WORD_ZERO;
      // Unmapped holes read as zero so the master never stalls
      if (region != uasd_pkg::RG_NONE) begin
         lane_word = REGION_RDATA[region];
      end
      if (bus.byte_acc) begin
         // Byte result is right-justified with a zero upper byte
         rdata_next = {uasd_pkg::BYTE_ZERO, odd ? lane_word[15:8] : lane_word[7:0]};
      end else begin
         // Byte peripheral upper lane is passed through as found, not defined
         rdata_next = lane_word;
      end
   end

   // Access faults: odd words or fetches, words to the function area,
   // odd bytes in the word peripheral region
   always_comb begin
      fault = 1'b0;
      if (!bus.byte_acc && odd) begin
         fault = 1'b1;
      end
      if (bus.fetch && odd) begin
         fault = 1'b1;
      end
      if (!bus.byte_acc && (region == uasd_pkg::RG_SFB)) begin
         fault = 1'b1;
      end
      if (bus.byte_acc && odd && (region == uasd_pkg::RG_PER16)) begin
         fault = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Completion: one ack per request, one cycle after it is taken
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= live;
      end
   end

   // Read data captured in the select cycle
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         rdata_reg <= uasd_pkg::WORD_ZERO;
      end else if (live && !bus.wr) begin
         rdata_reg <= rdata_next;
      end
   end

   // Status of the access just taken
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         fault_reg <= 1'b0;
         vec_reg <= 1'b0;
      end else if (live) begin
         fault_reg <= fault;
         vec_reg <= (bus.shared_address_bus >= uasd_pkg::VEC_LO);
      end
   end

   assign bus.ack = ack_reg;
   assign bus.shared_data_bus_rd = rdata_reg;
   assign ACCESS_FAULT = fault_reg;
   assign VECTOR_HIT = vec_reg;

endmodule
`default_nettype wire

/* File: bench/uasd_checker.sv */
// Purpose: Assertions on the shared bus between the master end and the decoder end
// Assumes: One clock domain; region bounds match those given to both ends
// Notes: Sees only the bus signals, instantiated beside the interface
`timescale 1ns/1ns
`default_nettype none
module uasd_checker #(
   parameter logic [15:0] RAM_HI = 16'h09ff,
   parameter logic [15:0] PMEM_LO = 16'hf000
) (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RESET,
   // Bus request side
   input wire logic req,
   input wire logic wr,
   input wire logic byte_acc,
   input wire logic fetch,
   input wire logic [15:0] shared_address_bus,
   input wire logic [15:0] shared_data_bus_wr,
   // Bus answer side
   input wire logic ack,
   input wire logic [15:0] shared_data_bus_rd
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (RESET);

   logic live;  // Request taken at the coming edge
   logic hole;  // Address between fitted RAM and program memory
   assign live = req && !ack;
   assign hole = (shared_address_bus > RAM_HI) && (shared_address_bus < PMEM_LO);

   ack_follows_req_a: assert property (live |=> ack)
      else $error("ack missing one cycle after request");
   ack_single_pulse_a: assert property (ack |=> !ack)
      else $error("ack longer than one cycle");
   req_released_a: assert property (ack |=> !req)
      else $error("request not dropped after ack");
   req_held_a: assert property (live |=> $stable(shared_address_bus) && $stable(wr)
      && $stable(shared_data_bus_wr) && $stable(byte_acc))
      else $error("request changed before ack");
   fetch_even_word_a: assert property (req && fetch |-> !shared_address_bus[0]
      && !byte_acc && !wr)
      else $error("fetch not an even word read");
   word_even_addr_a: assert property (req && !byte_acc |-> !shared_address_bus[0])
      else $error("word access at odd address");
   func_area_byte_a: assert property (req && (shared_address_bus <= 16'h000f)
      |-> byte_acc)
      else $error("word access to function byte area");
   word_per_even_a: assert property (req && byte_acc && (shared_address_bus[15:8] == 8'h01)
      |-> !shared_address_bus[0])
      else $error("odd byte access to word peripheral");
   byte_upper_zero_a: assert property (ack && byte_acc && !wr
      |-> shared_data_bus_rd[15:8] == 8'h00)
      else $error("byte read upper lane not zero");
   hole_reads_zero_a: assert property (ack && !wr && hole
      |-> shared_data_bus_rd == 16'h0000)
      else $error("unmapped read not zero");

   // Main scenarios reached
   cover property (ack && byte_acc && !wr);
   cover property (ack && wr && !byte_acc);
   cover property (ack && fetch);
endmodule
`default_nettype wire

/* File: bench/tb_unified_address_space_decoder.sv */
// Purpose: Drives user commands into the master end and models region memory
// Assumes: Master and decoder joined over one bus interface
// Notes: Every region reads one shared byte image
`timescale 1ns/1ns
`default_nettype none
module tb_unified_address_space_decoder;
   // ----------------------------------------------------------------
   // Settings and signals
   // ----------------------------------------------------------------
   localparam logic [15:0] RAM_TOP = 16'h09ff;   // Fitted RAM top
   localparam logic [15:0] PMEM_BASE = 16'hf000; // Fitted program memory start
   localparam logic [15:0] ALL = 16'hffff;       // Compare every bit
   // Command codes {error expected, write, byte, fetch}
   localparam logic [3:0] RW = 4'h0, RB = 4'h2, FW = 4'h1, FB = 4'h3;
   localparam logic [3:0] WW = 4'h4, WB = 4'h6, E = 4'h8;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic cmd_valid = 1'b0, cmd_write = 1'b0, cmd_byte = 1'b0, cmd_fetch = 1'b0;
   logic [15:0] cmd_addr = 16'h0000, cmd_wdata = 16'h0000;
   logic cmd_ready, rsp_valid, rsp_error, region_we, vec_hit, acc_fault;
   logic [15:0] rsp_data, region_addr, region_wdata;
   logic [uasd_pkg::NUM_REGIONS-1:0] region_sel;
   logic [1:0] region_be;
   logic [uasd_pkg::NUM_REGIONS-1:0][15:0] region_rdata;
   logic [7:0] mem [0:65535]; // Byte image behind all regions
   int mismatches = 0;
   int tests_run = 0;

   uasd_bus_if bus_i();
   always #2 mclk = ~mclk;

   uasd_master #(.RAM_HI(RAM_TOP), .PMEM_LO(PMEM_BASE)) uasd_master_i (
      .MCLK(mclk), .RESET(reset), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
      .CMD_WRITE(cmd_write), .CMD_BYTE(cmd_byte), .CMD_FETCH(cmd_fetch),
      .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata), .RSP_VALID(rsp_valid),
      .RSP_ERROR(rsp_error), .RSP_DATA(rsp_data), .bus(bus_i));
   uasd_decoder #(.RAM_HI(RAM_TOP), .PMEM_LO(PMEM_BASE)) uasd_decoder_i (
      .MCLK(mclk), .RESET(reset), .bus(bus_i), .REGION_SEL(region_sel),
      .REGION_ADDR(region_addr), .REGION_WE(region_we), .REGION_BE(region_be),
      .REGION_WDATA(region_wdata), .REGION_RDATA(region_rdata),
      .ACCESS_FAULT(acc_fault), .VECTOR_HIT(vec_hit));
   uasd_checker #(.RAM_HI(RAM_TOP), .PMEM_LO(PMEM_BASE)) uasd_checker_i (
      .MCLK(mclk), .RESET(reset), .req(bus_i.req), .wr(bus_i.wr),
      .byte_acc(bus_i.byte_acc), .fetch(bus_i.fetch),
      .shared_address_bus(bus_i.shared_address_bus),
      .shared_data_bus_wr(bus_i.shared_data_bus_wr), .ack(bus_i.ack),
      .shared_data_bus_rd(bus_i.shared_data_bus_rd));

   // ----------------------------------------------------------------
   // Region model
   // ----------------------------------------------------------------
   // Same word to every region, so the decoder's select does not change the result
   assign region_rdata = {5{mem[region_addr + 16'h0001], mem[region_addr]}};
   // Lane writes gated by a select; stray strobes are caught by the monitor below
   always @(posedge mclk) begin
      if (region_we && |region_sel) begin
         if (region_be[0]) mem[region_addr] <= region_wdata[7:0];
         if (region_be[1]) mem[region_addr + 16'h0001] <= region_wdata[15:8];
      end
   end

   // Expected one-hot select, written out apart from the design's decode
   function automatic logic [4:0] sel_for(input logic [15:0] a);
      if (a <= 16'h000f) return 5'h01;
      if (a <= 16'h00ff) return 5'h02;
      if (a <= 16'h01ff) return 5'h04;
      if (a <= RAM_TOP) return 5'h08;
      if (a >= PMEM_BASE) return 5'h10;
      return 5'h00;
   endfunction

   // Select only in the live cycle, and always the right region
   always @(negedge mclk) begin
      logic [4:0] exp_sel;
      exp_sel = (bus_i.req && !bus_i.ack) ? sel_for(bus_i.shared_address_bus) : 5'h00;
      if (!reset) check({11'h000, region_sel}, {11'h000, exp_sel});
      // Strobe only for writable regions; program memory and holes never see one
      if (!reset) check({15'h0000, region_we}, {15'h0000, bus_i.wr && |exp_sel[3:0]});
      // Master issues only legal accesses, so the fault status must stay clear
      if (!reset) check({15'h0000, acc_fault}, 16'h0000);
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t ns: seen %h, expected %h", $time, seen, exp);
      end
   endtask

   // One command at a falling edge; waits are bounded so a hang is caught
   task automatic xfer(input logic [3:0] op, input logic [15:0] a, d, exp, msk);
      int n;
      {cmd_write, cmd_byte, cmd_fetch} = op[2:0];
      cmd_addr = a;
      cmd_wdata = d;
      cmd_valid = 1'b1;
      n = 0;
      while (!cmd_ready && n < 10) begin
         @(negedge mclk);
         n++;
      end
      @(negedge mclk);
      cmd_valid = 1'b0;
      n = 0;
      while (!rsp_valid && n < 10) begin
         @(negedge mclk);
         n++;
      end
      if (n == 10) begin
         mismatches++;
         $display("ERROR at %0t ns: no response", $time);
      end
      check({15'h0000, rsp_error}, {15'h0000, op[3]});
      check(rsp_data & msk, exp);
   endtask

   task automatic note(input string s);
      $display("Test %s done", s);
   endtask

   task automatic print_verdict();
      $display("Counts: %0d comparisons, %0d mismatches", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   // 33 commands of under 6 cycles each; the limit leaves wide margin
   initial begin
      #20000;
      mismatches++;
      $display("ERROR at %0t ns: watchdog expired", $time);
      print_verdict();
   end

   initial begin
      // Hole and program memory hold a pattern, so zero reads mean something
      for (int a = 0; a < 65536; a++) mem[a] = (a >= 16'h0a00) ? (a[7:0] ^ 8'h5a) : 8'h00;
      repeat (20) @(negedge mclk);
      reset = 1'b0;
      @(negedge mclk);
      xfer(WW, 16'h0204, 16'h1234, 16'h0000, ALL);
      xfer(RB, 16'h0204, 16'h0000, 16'h0034, ALL);
      xfer(RB, 16'h0205, 16'h0000, 16'h0012, ALL);
      xfer(WB, 16'h0207, 16'h00ab, 16'h0000, ALL);
      xfer(RW, 16'h0206, 16'h0000, 16'hab00, ALL);
      xfer(WB, 16'h09ff, 16'h0077, 16'h0000, ALL);
      xfer(RB, 16'h09ff, 16'h0000, 16'h0077, ALL);
      xfer(FW, 16'h0204, 16'h0000, 16'h1234, ALL);
      note("ram");
      xfer(WW, 16'h0020, 16'hbeef, 16'h0000, ALL);
      xfer(RB, 16'h0021, 16'h0000, 16'h0000, ALL);
      xfer(RW, 16'h0020, 16'h0000, 16'h00ef, 16'h00ff);
      xfer(WB, 16'h00ff, 16'h0011, 16'h0000, ALL);
      xfer(RB, 16'h00ff, 16'h0000, 16'h0011, ALL);
      note("byte peripherals");
      xfer(WW, 16'h0100, 16'hcafe, 16'h0000, ALL);
      xfer(RW, 16'h0100, 16'h0000, 16'hcafe, ALL);
      xfer(RB, 16'h0100, 16'h0000, 16'h00fe, ALL);
      xfer(RB | E, 16'h0101, 16'h0000, 16'h0000, ALL);
      note("word peripherals");
      xfer(WB, 16'h000f, 16'h005a, 16'h0000, ALL);
      xfer(RW | E, 16'h0000, 16'h0000, 16'h0000, ALL);
      xfer(WW | E, 16'h000e, 16'h1111, 16'h0000, ALL);
      xfer(RB, 16'h000f, 16'h0000, 16'h005a, ALL);
      note("function area");
      xfer(RW | E, 16'h0203, 16'h0000, 16'h0000, ALL);
      xfer(FW | E, 16'h0205, 16'h0000, 16'h0000, ALL);
      xfer(FB | E, 16'h0204, 16'h0000, 16'h0000, ALL);
      note("alignment");
      xfer(FW, 16'hfffe, 16'h0000, 16'ha5a4, ALL);
      check({15'h0000, vec_hit}, 16'h0001);
      xfer(RW, 16'hffde, 16'h0000, 16'h8584, ALL);
      check({15'h0000, vec_hit}, 16'h0000);
      xfer(RW, 16'hffe0, 16'h0000, 16'hbbba, ALL);
      check({15'h0000, vec_hit}, 16'h0001);
      xfer(RB, 16'hfffd, 16'h0000, 16'h00a7, ALL);
      xfer(WW, 16'hf000, 16'h0000, 16'h0000, ALL);
      xfer(RW, 16'hf000, 16'h0000, 16'h5b5a, ALL);
      note("program memory");
      xfer(WW, 16'h0a00, 16'h7777, 16'h0000, ALL);
      xfer(RW, 16'h0a00, 16'h0000, 16'h0000, ALL);
      xfer(RB, 16'heffd, 16'h0000, 16'h0000, ALL);
      note("unmapped");
      print_verdict();
   end
endmodule
`default_nettype wire
